// ==== sac_core_model.sv ====
// stand-in for the analog converter core at the far side of the block
`timescale 1ns/10ps
module sac_core_model (
  input wire logic clock,
  input sac_pkg::sac_analog_t analog,
  input wire logic [11:0] level,
  output logic [11:0] core_result
);
  logic [11:0] held;
  initial held = 12'h000;
  // the input is captured only while the sample switch is closed
  always @(posedge clock) begin
    if (analog.sample && analog.enable) begin
      held <= level;
    end
  end
  // powered down the lines carry junk, so a stale value never passes
  assign core_result = analog.enable ? held : ~held;
endmodule

// ==== sac_ctrl.sv ====
// control logic of the successive-approximation converter
//**********************************************************************
// Functional notes
// [R1] prescaler counts whenever converter enable is set; the code also clears it on an auto-trigger start
// [R2] conversion starts on next converter clock edge
// [R3] normal conversion takes 15 converter clocks
// [R4] first conversion waits 50 initialisation clocks
// [R5] sample at 1.5, result at 14.5
// [R6] result, flag set, start clear together
// [R7] selections copied to active when flag sets
// [R8] software avoids select change first clock
// [R9] software changes selection only in safe windows
// [R10] input above reference yields full scale
// [R11] power-up applies low cal, spare holds high
// [R12] calibration write moves old value to spare
// [R13] right alignment splits 7:0 and 11:8
// [R14] left alignment splits 11:4 and 3:0
// [R15] start bit launches single or first conversion
// [R16] auto trigger starts on selected rising edge
// [R17] interrupt from flag, enable, global; clears
// [R18] prescaler codes give 2 up to 128
// [R19] comparator negative input selection by code
// [R20] comparator trigger select picks comparator output
// [R21] trigger source field encodes eight sources
// [R22] busy ignores triggers, start bit stays high
//**********************************************************************
`timescale 1ns/10ps
module sac_ctrl #(
  parameter logic [7:0] LOW_CAL = 8'h80,
  parameter logic [7:0] HIGH_CAL = 8'h80
) (
  input wire logic clock,
  input wire logic rst,
  input sac_pkg::sac_bus_t bus,
  output logic [7:0] rdata,
  input wire logic global_irq_enable,
  input wire logic irq_serviced,
  input sac_pkg::sac_trig_t trig_async,
  input wire logic [11:0] core_result,
  input wire logic core_above_ref,
  output sac_pkg::sac_analog_t analog,
  output logic [1:0] comp0_negative_select,
  output logic [7:0] active_reference_calibration,
  output logic irq
);
  //********************************************************************
  // registers
  //********************************************************************
  logic [7:0] csa, csb, sel_tmp, test_mode, did0, spare_cal;
  logic [7:0] res_lo, res_hi;
  logic [4:0] chan_act;
  logic [1:0] ref_act;
  logic [6:0] pre_cnt;
  logic [5:0] init_cnt;
  logic [4:0] half_cnt;
  logic ck_phase, busy, sampling, trig_prev, free_pend;
  logic trig_start;
  sac_pkg::sac_trig_t trig_m, trig_s;

  wire en = csa[sac_pkg::CSA_EN];
  wire wr_csa = bus.wr && bus.addr == sac_pkg::ADDR_CSA;
  wire wr_csb = bus.wr && bus.addr == sac_pkg::ADDR_CSB;
  wire wr_sel = bus.wr && bus.addr == sac_pkg::ADDR_SEL;
  wire wr_cal = bus.wr && bus.addr == sac_pkg::ADDR_CAL;

  //********************************************************************
  // prescaler
  //********************************************************************
  logic [6:0] pre_mask;
  always_comb begin
    case (csa[2:0])
      3'h0, 3'h1: pre_mask = 7'h00; // [R18]
      3'h2: pre_mask = 7'h01;
      3'h3: pre_mask = 7'h03;
      3'h4: pre_mask = 7'h07;
      3'h5: pre_mask = 7'h0f;
      3'h6: pre_mask = 7'h1f;
      default: pre_mask = 7'h3f;
    endcase
  end
  // half-period tick of the converter clock; one half of each period
  wire half_tick = en && ((pre_cnt & pre_mask) == pre_mask);
  wire rise_tick = half_tick && ck_phase;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_cnt <= 7'h00;
      ck_phase <= 1'b0;
    end else if (!en || trig_start) begin
      // a trigger resets the prescaler so the start lands cleanly
      pre_cnt <= 7'h00;
      ck_phase <= 1'b0;
    end else begin
      pre_cnt <= pre_cnt + 7'h01; // [R1]
      if (half_tick) begin
        ck_phase <= ~ck_phase;
      end
    end
  end

  //********************************************************************
  // triggers
  //********************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trig_m <= '0;
      trig_s <= '0;
    end else begin
      trig_m <= trig_async;
      trig_s <= trig_m;
    end
  end

  wire comp_sel = csb[sac_pkg::CSB_COMPARATOR_TRIGGER_SELECT] ? trig_s.comp1 : trig_s.comp0; // [R20]
  logic trig_lvl;
  always_comb begin
    case (csb[2:0]) // [R21]
      sac_pkg::TS_COMP: trig_lvl = comp_sel;
      sac_pkg::TS_EXT0: trig_lvl = trig_s.ext0;
      sac_pkg::TS_T0CM: trig_lvl = trig_s.t0_cmp;
      sac_pkg::TS_T0OV: trig_lvl = trig_s.t0_ovf;
      sac_pkg::TS_T1CB: trig_lvl = trig_s.t1_cmpb;
      sac_pkg::TS_T1OV: trig_lvl = trig_s.t1_ovf;
      sac_pkg::TS_T1CP: trig_lvl = trig_s.t1_cap;
      default: trig_lvl = 1'b0;
    endcase
  end
  wire ate = csa[sac_pkg::CSA_ATE];
  wire free_mode = ate && csb[2:0] == sac_pkg::TS_FREE;
  // edges during a conversion are dropped, not queued
  assign trig_start = ate && en && !free_mode && trig_lvl && !trig_prev
                      && !busy && !csa[sac_pkg::CSA_SC]; // [R16] [R22]

  //********************************************************************
  // sequencer
  //********************************************************************
  wire init_done = init_cnt == 6'(sac_pkg::INIT_CYCLES);
  wire sc = csa[sac_pkg::CSA_SC];
  // start bit (or free-running restart) begins on the next rise
  wire go = rise_tick && !busy && init_done && (sc || free_pend); // [R2] [R15]
  wire finish = busy && half_tick &&
                half_cnt == 5'(sac_pkg::RESULT_HALF - 1); // [R3] [R5]
  wire [11:0] result = core_above_ref ? sac_pkg::FULL_SCALE
                                      : core_result; // [R10]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_cnt <= 6'h00;
      busy <= 1'b0;
      half_cnt <= 5'h00;
      sampling <= 1'b0;
      trig_prev <= 1'b0;
      free_pend <= 1'b0;
    end else begin
      trig_prev <= trig_lvl;
      if (!en) begin
        init_cnt <= 6'h00;
        busy <= 1'b0;
        sampling <= 1'b0;
        free_pend <= 1'b0;
      end else begin
        if (rise_tick && !init_done) begin
          init_cnt <= init_cnt + 6'h01; // [R4]
        end
        if (go) begin
          busy <= 1'b1;
          half_cnt <= 5'h00;
          sampling <= 1'b1;
          free_pend <= 1'b0;
        end else if (busy && half_tick) begin
          half_cnt <= half_cnt + 5'h01;
          if (half_cnt == 5'(sac_pkg::SAMPLE_HALF - 1)) begin
            sampling <= 1'b0; // [R5]
          end
          if (finish) begin
            busy <= 1'b0;
            free_pend <= free_mode;
          end
        end
      end
    end
  end

  //********************************************************************
  // control/status a
  //********************************************************************
  wire clr_if = (wr_csa && bus.wdata[sac_pkg::CSA_IF]) || irq_serviced;
  logic [7:0] next_csa;
  always_comb begin
    next_csa = csa;
    if (wr_csa) begin
      next_csa = {bus.wdata[7], csa[6] | bus.wdata[6], bus.wdata[5],
                  csa[4], bus.wdata[3:0]};
    end
    if (clr_if) begin
      next_csa[sac_pkg::CSA_IF] = 1'b0; // [R17]
    end
    if (trig_start) begin
      next_csa[sac_pkg::CSA_SC] = 1'b1; // [R22]
    end
    if (go) begin
      // free-running restarts must show busy on the start bit as well
      next_csa[sac_pkg::CSA_SC] = 1'b1; // [R22]
    end
    if (finish) begin
      next_csa[sac_pkg::CSA_SC] = 1'b0; // [R6]
      next_csa[sac_pkg::CSA_IF] = 1'b1; // set wins over clear
    end
    if (!next_csa[sac_pkg::CSA_EN]) begin
      next_csa[sac_pkg::CSA_SC] = 1'b0;
    end
  end

  //********************************************************************
  // register file
  //********************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      csa <= sac_pkg::RST_CSA;
      csb <= 8'h00;
      sel_tmp <= 8'h00;
      test_mode <= sac_pkg::RST_TEST;
      did0 <= 8'h00;
      res_lo <= 8'h00;
      res_hi <= 8'h00;
      chan_act <= 5'h00;
      ref_act <= 2'h0;
      active_reference_calibration <= LOW_CAL; // [R11]
      spare_cal <= HIGH_CAL; // [R11]
    end else begin
      csa <= next_csa;
      if (wr_csb) csb <= bus.wdata;
      if (wr_sel) sel_tmp <= bus.wdata;
      if (bus.wr && bus.addr == sac_pkg::ADDR_TEST) test_mode <= bus.wdata;
      if (bus.wr && bus.addr == sac_pkg::ADDR_DID0) did0 <= bus.wdata;
      if (wr_cal) begin
        active_reference_calibration <= bus.wdata;
        spare_cal <= active_reference_calibration; // [R12]
      end
      if (finish) begin
        if (sel_tmp[sac_pkg::SEL_LAR]) begin
          res_hi <= result[11:4]; // [R14]
          res_lo <= {result[3:0], 4'h0};
        end else begin
          res_hi <= {4'h0, result[11:8]}; // [R13]
          res_lo <= result[7:0];
        end
        chan_act <= sel_tmp[4:0]; // [R7]
        ref_act <= sel_tmp[7:6];
      end else begin
        if (bus.wr && bus.addr == sac_pkg::ADDR_RES_LO) res_lo <= bus.wdata;
        if (bus.wr && bus.addr == sac_pkg::ADDR_RES_HI) res_hi <= bus.wdata;
        if (!busy && !sc) begin
          // idle: a new selection reaches the multiplexer at once
          chan_act <= sel_tmp[4:0]; // [R7]
          ref_act <= sel_tmp[7:6];
        end
      end
    end
  end

  //********************************************************************
  // read port and outputs
  //********************************************************************
  logic [7:0] next_rdata;
  always_comb begin
    case (bus.addr)
      sac_pkg::ADDR_RES_LO: next_rdata = res_lo;
      sac_pkg::ADDR_RES_HI: next_rdata = res_hi;
      sac_pkg::ADDR_CSA: next_rdata = csa;
      sac_pkg::ADDR_CSB: next_rdata = {csb[7:4], 1'b0, csb[2:0]};
      sac_pkg::ADDR_SEL: next_rdata = sel_tmp;
      sac_pkg::ADDR_TEST: next_rdata = test_mode;
      sac_pkg::ADDR_DID0: next_rdata = did0;
      sac_pkg::ADDR_CAL: next_rdata = active_reference_calibration;
      sac_pkg::ADDR_CAL2: next_rdata = spare_cal;
      default: next_rdata = 8'h00;
    endcase
  end

  logic [1:0] next_neg;
  always_comb begin
    case ({csb[sac_pkg::CSB_ACME_HI], csb[sac_pkg::CSB_ACME_LO]})
      2'h0: next_neg = sac_pkg::NEG_PIN; // [R19]
      2'h1: next_neg = sac_pkg::NEG_MUX;
      default: next_neg = sac_pkg::NEG_OPA;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      analog <= '0;
      comp0_negative_select <= sac_pkg::NEG_PIN;
      irq <= 1'b0;
    end else begin
      rdata <= bus.rd ? next_rdata : 8'h00;
      analog <= '{channel_select: chan_act, reference_select: ref_act,
                  sample: sampling, enable: en};
      comp0_negative_select <= next_neg;
      irq <= next_csa[sac_pkg::CSA_IF] && next_csa[sac_pkg::CSA_IE]
             && global_irq_enable; // [R17]
    end
  end
endmodule

// ==== sac_ctrl_chk.sv ====
// port assertions for the converter control block
`timescale 1ns/10ps
module sac_ctrl_chk (
  input wire logic clock,
  input wire logic rst,
  input sac_pkg::sac_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic global_irq_enable,
  input wire logic irq_serviced,
  input sac_pkg::sac_trig_t trig_async,
  input wire logic [11:0] core_result,
  input wire logic core_above_ref,
  input sac_pkg::sac_analog_t analog,
  input wire logic [1:0] comp0_negative_select,
  input wire logic [7:0] active_reference_calibration,
  input wire logic irq
);
  //****************************************
  // checks
  //****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_irq_global: assert property (!global_irq_enable |=> !irq)
    else $error("irq high with global enable off");
  a_sample_width: assert property ($rose(analog.sample) |->
    analog.sample[*3])
    else $error("sample window too short");
  a_sample_enabled: assert property (analog.sample |-> analog.enable)
    else $error("sample while disabled");
  a_sel_steady: assert property (analog.sample ##1 analog.sample |->
    $stable(analog.channel_select) && $stable(analog.reference_select))
    else $error("selection moved during sampling");
  a_enable_off: assert property (bus.wr && bus.addr == sac_pkg::ADDR_CSA
    && !bus.wdata[7] |-> ##[1:3] !analog.enable)
    else $error("enable did not drop");
  a_comp0_code: assert property ($past(bus.wr, 2) && !$past(bus.wr) &&
    $past(bus.addr, 2) == sac_pkg::ADDR_CSB |-> comp0_negative_select ==
    ($past(bus.wdata[7], 2) ? 2'h2 : {1'b0, $past(bus.wdata[6], 2)}))
    else $error("comparator input code wrong");
  a_cal_follow: assert property ($past(bus.wr, 2) && !$past(bus.wr) &&
    $past(bus.addr, 2) == sac_pkg::ADDR_CAL |->
    active_reference_calibration == $past(bus.wdata, 2))
    else $error("calibration output not updated");
  a_csb_wonly: assert property ($past(bus.rd) &&
    $past(bus.addr) == sac_pkg::ADDR_CSB |-> !rdata[3])
    else $error("write-only bit read back");
endmodule
bind sac_ctrl sac_ctrl_chk i_chk (.clock(clock), .rst(rst), .bus(bus),
  .rdata(rdata), .global_irq_enable(global_irq_enable),
  .irq_serviced(irq_serviced), .trig_async(trig_async),
  .core_result(core_result), .core_above_ref(core_above_ref),
  .analog(analog), .comp0_negative_select(comp0_negative_select),
  .active_reference_calibration(active_reference_calibration), .irq(irq));

// ==== sac_ctrl_tb.sv ====
// self-checking testbench for the converter control block
`timescale 1ns/10ps
module sac_ctrl_tb;
  localparam logic [7:0] LOW = 8'h3c; // arbitrary
  localparam logic [7:0] HIGH = 8'ha5; // arbitrary
  logic clock = 1'b0;
  logic rst = 1'b1;
  sac_pkg::sac_bus_t bus = '0;
  sac_pkg::sac_trig_t trig = '0;
  sac_pkg::sac_analog_t analog;
  logic gie = 1'b0;
  logic serv = 1'b0;
  logic above = 1'b0;
  logic irq;
  logic [1:0] neg;
  logic [7:0] rdata, cal, rv;
  logic [11:0] level = 12'h5a3;
  logic [11:0] core_result;
  int n_errors = 0;
  int compares = 0;
  always #2 clock = ~clock;
  sac_ctrl #(.LOW_CAL(LOW), .HIGH_CAL(HIGH)) i_dut (.clock(clock),
    .rst(rst), .bus(bus), .rdata(rdata), .global_irq_enable(gie),
    .irq_serviced(serv), .trig_async(trig), .core_result(core_result),
    .core_above_ref(above), .analog(analog),
    .comp0_negative_select(neg), .active_reference_calibration(cal),
    .irq(irq));
  sac_core_model i_core (.clock(clock), .analog(analog), .level(level),
    .core_result(core_result));
  //****************************************
  // bus and checking tasks
  //****************************************
  task automatic close_out;
    $display("mismatches %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [11:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 rv = rdata;
    @(posedge clock);
  endtask
  // polls the start bit; a bound that runs out ends the run
  task automatic start(input logic [7:0] csa, output int n);
    wr(sac_pkg::ADDR_CSA, csa);
    n = 0;
    do begin
      rd(sac_pkg::ADDR_CSA);
      n += 2;
    end while (rv[6] && n < 8000);
    if (rv[6]) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic wait_flag(output int n);
    n = 0;
    do begin
      rd(sac_pkg::ADDR_CSA);
      n += 2;
    end while (!rv[4] && n < 8000);
    if (!rv[4]) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic pulse(input int i);
    trig[i] <= 1'b1;
    repeat (4) @(posedge clock);
    trig[i] <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  //****************************************
  // scenarios
  //****************************************
  task automatic t_regs;
    rd(sac_pkg::ADDR_CSA);
    check("csa", rv, sac_pkg::RST_CSA);
    rd(sac_pkg::ADDR_TEST);
    check("test", rv, sac_pkg::RST_TEST);
    rd(8'h00);
    check("unmapped", rv, 12'h0);
    check("cal", cal, LOW);
    rd(sac_pkg::ADDR_CAL2);
    check("spare", rv, HIGH);
    wr(sac_pkg::ADDR_CAL, rv);
    check("cal", cal, HIGH);
    rd(sac_pkg::ADDR_CAL2);
    check("spare", rv, LOW);
    for (int c = 0; c < 4; c++) begin
      wr(sac_pkg::ADDR_CSB, 8'(c << 6));
      @(negedge clock);
      check("neg", neg, c > 1 ? 12'h2 : 12'(c));
      @(posedge clock);
    end
  endtask
  task automatic t_conv;
    int n;
    int f;
    wr(sac_pkg::ADDR_SEL, 8'h03);
    wr(sac_pkg::ADDR_CSA, 8'h80);
    start(8'hd0, n);
    check("init", n >= 100, 1);
    check("flag", rv[4], 1);
    rd(sac_pkg::ADDR_RES_LO);
    check("lo", rv, level[7:0]);
    rd(sac_pkg::ADDR_RES_HI);
    check("hi", rv[3:0], level[11:8]);
    wr(sac_pkg::ADDR_SEL, 8'h23);
    start(8'hd0, n);
    rd(sac_pkg::ADDR_RES_HI);
    check("hi", rv, level[11:4]);
    rd(sac_pkg::ADDR_RES_LO);
    check("lo", rv[7:4], level[3:0]);
    above <= 1'b1;
    start(8'hd0, n);
    rd(sac_pkg::ADDR_RES_HI);
    check("full", rv, 12'hff);
    above <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      f = c < 2 ? 2 : 1 << c;
      start(8'(8'hd0 + c), n);
      check("time", n >= 29 * f / 2 - 2 && n <= 31 * f / 2 + 6, 1);
    end
  endtask
  task automatic t_irq;
    int n;
    gie <= 1'b1;
    start(8'hd8, n);
    repeat (2) @(posedge clock);
    check("irq", irq, 1);
    gie <= 1'b0;
    repeat (2) @(posedge clock);
    check("irq", irq, 0);
    gie <= 1'b1;
    serv <= 1'b1;
    @(posedge clock);
    serv <= 1'b0;
    repeat (2) @(posedge clock);
    check("serviced", irq, 0);
    start(8'hd8, n);
    wr(sac_pkg::ADDR_CSA, 8'h98);
    repeat (2) @(posedge clock);
    check("cleared", irq, 0);
  endtask
  task automatic t_trig;
    int n;
    int i;
    for (int k = 0; k < 8; k++) begin
      i = k == 0 ? 6 : (k == 1 ? 7 : 7 - k);
      wr(sac_pkg::ADDR_CSB, k == 0 ? 8'h09 : 8'(k));
      wr(sac_pkg::ADDR_CSA, 8'hb0);
      pulse(i);
      rd(sac_pkg::ADDR_CSA);
      check("busy", rv[6], 1);
      pulse(i);
      start(8'hb0 & 8'hef, n);
      check("done", rv[4], 1);
      repeat (40) @(posedge clock);
      rd(sac_pkg::ADDR_CSA);
      check("ignored", rv[6], 0);
    end
  endtask
  task automatic t_free;
    int n;
    wr(sac_pkg::ADDR_SEL, 8'h05);
    wr(sac_pkg::ADDR_CSB, 8'h00);
    wr(sac_pkg::ADDR_CSA, 8'hf0);
    wait_flag(n);
    wr(sac_pkg::ADDR_SEL, 8'h07);
    @(negedge clock);
    check("held chan", analog.channel_select, 12'h05);
    @(posedge clock);
    rd(sac_pkg::ADDR_CSA);
    check("restart", rv[6], 1);
    wr(sac_pkg::ADDR_CSA, 8'hf0);
    wait_flag(n);
    @(negedge clock);
    check("new chan", analog.channel_select, 12'h07);
    @(posedge clock);
    wr(sac_pkg::ADDR_CSA, 8'h00);
    @(negedge clock);
    check("enable", analog.enable, 0);
    @(posedge clock);
    rd(sac_pkg::ADDR_CSA);
    check("stopped", rv[6], 0);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_conv();
    t_irq();
    t_trig();
    t_free();
    close_out();
  end
endmodule

// ==== sac_pkg.sv ====
// package for the successive-approximation converter control block
package sac_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_RES_LO = 8'h78;
  localparam logic [7:0] ADDR_RES_HI = 8'h79;
  localparam logic [7:0] ADDR_CSA = 8'h7a;
  localparam logic [7:0] ADDR_CSB = 8'h7b;
  localparam logic [7:0] ADDR_SEL = 8'h7c;
  localparam logic [7:0] ADDR_TEST = 8'h7d;
  localparam logic [7:0] ADDR_DID0 = 8'h7e;
  localparam logic [7:0] ADDR_CAL = 8'hc8;
  localparam logic [7:0] ADDR_CAL2 = 8'hce;
  // reset values
  localparam logic [7:0] RST_CSA = 8'h02;
  localparam logic [7:0] RST_TEST = 8'h01;
  // control/status a field positions
  localparam int CSA_EN = 7;
  localparam int CSA_SC = 6;
  localparam int CSA_ATE = 5;
  localparam int CSA_IF = 4;
  localparam int CSA_IE = 3;
  // control/status b field positions
  localparam int CSB_ACME_HI = 7;
  localparam int CSB_ACME_LO = 6;
  localparam int CSB_COMPARATOR_TRIGGER_SELECT = 3;
  // select register field positions
  localparam int SEL_LAR = 5;
  // timing in converter clocks; SAMPLE_HALF and RESULT_HALF in half converter clocks
  localparam int INIT_CYCLES = 50;
  localparam int CONV_CYCLES = 15;
  localparam int SAMPLE_HALF = 3;
  localparam int RESULT_HALF = 29;
  localparam logic [11:0] FULL_SCALE = 12'hfff;
  // trigger source codes
  localparam logic [2:0] TS_FREE = 3'h0;
  localparam logic [2:0] TS_COMP = 3'h1;
  localparam logic [2:0] TS_EXT0 = 3'h2;
  localparam logic [2:0] TS_T0CM = 3'h3;
  localparam logic [2:0] TS_T0OV = 3'h4;
  localparam logic [2:0] TS_T1CB = 3'h5;
  localparam logic [2:0] TS_T1OV = 3'h6;
  localparam logic [2:0] TS_T1CP = 3'h7;
  // comparator 0 negative input encodings
  localparam logic [1:0] NEG_PIN = 2'h0;
  localparam logic [1:0] NEG_MUX = 2'h1;
  localparam logic [1:0] NEG_OPA = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_t;

  typedef struct packed {
    logic comp0;
    logic comp1;
    logic ext0;
    logic t0_cmp;
    logic t0_ovf;
    logic t1_cmpb;
    logic t1_ovf;
    logic t1_cap;
  } sac_trig_t;

  typedef struct packed {
    logic [4:0] channel_select;
    logic [1:0] reference_select;
    logic sample;
    logic enable;
  } sac_analog_t;
endpackage
